// File: hw/csod_pkg.sv
// package: register map, field layout and cycle constants of the chip-select decode
package csod_pkg;
  localparam int NUM_SEL = 12;
  // apb byte offsets: base regs then option regs, boot select at index 0
  localparam logic [7:0] BASE_OFS = 8'h00;
  localparam logic [7:0] OPT_OFS = 8'h40;
  localparam logic [7:0] PIN_OFS = 8'h80;
  localparam logic [7:0] STAT_OFS = 8'h84;
  localparam logic [15:0] BOOT_OPT_RST = 16'h7b70;
  localparam logic [15:0] OPT_RST = 16'h0000;
  localparam logic [15:0] BOOT_BASE_RST = 16'h0007;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [3:0] ACK_FAST = 4'he;
  localparam logic [3:0] ACK_EXT = 4'hf;
  localparam logic [1:0] SP_CPU = 2'h0;
  localparam logic [1:0] SP_USER = 2'h1;
  localparam logic [1:0] SP_SUP = 2'h2;
  localparam logic [1:0] SP_BOTH = 2'h3;
  localparam logic [1:0] PIN_CS16 = 2'h3;
  localparam logic [1:0] PIN_CS8 = 2'h2;
  // clock counts to internal termination: base plus the acknowledge code, or the fast count
  localparam logic [4:0] BASE_CYCLES = 5'h3;
  localparam logic [4:0] FAST_CYCLES = 5'h2;

  typedef struct packed {
    logic mode;
    logic [1:0] byte_lane;
    logic [1:0] rw_qual;
    logic strobe_timing_select;
    logic [3:0] size_acknowledge_source;
    logic [1:0] space;
    logic [2:0] interrupt_level_match;
    logic autovector_enable;
  } csod_opt_t;

  typedef struct packed {
    logic [12:0] base_addr;
    logic [2:0] block_size_field;
  } csod_base_t;

  // one bus cycle of the internal master
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic rd;
    logic upper;
    logic lower;
    logic [1:0] space;
    logic iack;
  } csod_cyc_t;
endpackage

// File: hw/csod_top.sv
// chip-select option decode: base/option registers over apb and per-select gating and timing
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module csod_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire csod_pkg::csod_cyc_t bus_cyc,
  input wire logic address_strobe_line,
  input wire logic data_strobe_line,
  input wire logic ext_ack_in,
  output logic [csod_pkg::NUM_SEL-1:0] sel_n,
  output logic cycle_done,
  output logic autovector_out,
  output logic slow_cycle_pending,
  output logic [3:0] addr_top
);
  localparam int N = csod_pkg::NUM_SEL;

  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_s2_r;

  // register file: index 0 is the boot select
  logic [15:0] base_r [N];
  logic [15:0] opt_r [N];
  logic [2*N-1:0] pin_r;
  logic [15:0] match_r;

  wire logic apb_acc = psel && penable;
  wire logic [5:0] widx = paddr[7:2] - csod_pkg::OPT_OFS[7:2];
  wire logic in_base = paddr < csod_pkg::OPT_OFS && paddr[7:2] < 6'(N);
  wire logic in_opt = paddr >= csod_pkg::OPT_OFS && paddr < csod_pkg::PIN_OFS && widx < 6'(N);
  wire logic in_pin = paddr == csod_pkg::PIN_OFS;
  wire logic in_stat = paddr == csod_pkg::STAT_OFS;
  wire logic mapped = (in_base || in_opt || in_pin || in_stat) && paddr[1:0] == 2'h0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        base_r[i] <= (i == 0) ? csod_pkg::BOOT_BASE_RST : csod_pkg::BASE_RST;
        opt_r[i] <= (i == 0) ? csod_pkg::BOOT_OPT_RST : csod_pkg::OPT_RST;
      end
      pin_r <= {N{csod_pkg::PIN_CS16}};
    end else if (apb_acc && pwrite && mapped) begin
      if (in_base) begin
        base_r[paddr[5:2]] <= pwdata[15:0];
      end
      if (in_opt) begin
        opt_r[widx[3:0]] <= pwdata[15:0];
      end
      if (in_pin) begin
        pin_r <= pwdata[2*N-1:0];
      end
    end
  end

  // one-cycle answer: pready with read data in the access phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (in_base) begin
          prdata <= {16'h0000, base_r[paddr[5:2]]};
        end else if (in_opt) begin
          prdata <= {16'h0000, opt_r[widx[3:0]]};
        end else if (in_pin) begin
          prdata <= {{(32-2*N){1'b0}}, pin_r};
        end else if (in_stat) begin
          prdata <= {16'h0000, match_r};
        end
      end
    end
  end

  // address qualification
  wire logic top_ok = &(bus_cyc.addr[23:20]) == bus_cyc.addr[19]
                      && |(bus_cyc.addr[23:20]) == bus_cyc.addr[19];
  wire logic [1:0] cyc_space = bus_cyc.iack ? csod_pkg::SP_CPU : bus_cyc.space;

  logic [N-1:0] hit;
  logic [N-1:0] sync_hit;
  logic [N-1:0] strobe_ok;
  logic [N-1:0] ack_int;
  logic [N-1:0] autovector_enable_hit;
  logic [3:0] ack_code [N];

  for (genvar g = 0; g < N; g++) begin : g_sel
    csod_pkg::csod_opt_t o;
    csod_pkg::csod_base_t b;
    logic [12:0] mask;
    logic addr_ok;
    logic lane_ok;
    logic dir_ok;
    logic space_ok;
    logic is_cs;
    assign o = opt_r[g];
    assign b = base_r[g];
    always_comb begin
      unique case (b.block_size_field)
        3'h0: mask = 13'h1fff;
        3'h1: mask = 13'h1ffc;
        3'h2: mask = 13'h1ff8;
        3'h3: mask = 13'h1fe0;
        3'h4: mask = 13'h1fc0;
        3'h5: mask = 13'h1f80;
        3'h6: mask = 13'h1f00;
        3'h7: mask = 13'h1e00;
      endcase
    end
    assign addr_ok = ((bus_cyc.addr[23:11] ^ b.base_addr) & mask) == 13'h0000;
    assign is_cs = pin_r[2*g+1];
    always_comb begin
      if (pin_r[2*g +: 2] == csod_pkg::PIN_CS16) begin
        unique case (o.byte_lane)
          2'h0: lane_ok = 1'b0;
          2'h1: lane_ok = bus_cyc.lower;
          2'h2: lane_ok = bus_cyc.upper;
          2'h3: lane_ok = 1'b1;
        endcase
      end else begin
        lane_ok = 1'b1;
      end
    end
    assign dir_ok = bus_cyc.rd ? o.rw_qual[0] : o.rw_qual[1];
    always_comb begin
      unique case (o.space)
        csod_pkg::SP_CPU: space_ok = cyc_space == csod_pkg::SP_CPU
          && (!bus_cyc.iack || o.interrupt_level_match == 3'h0
              || o.interrupt_level_match == bus_cyc.addr[3:1]);
        csod_pkg::SP_USER: space_ok = 1'b0;
        csod_pkg::SP_SUP: space_ok = cyc_space == csod_pkg::SP_SUP;
        csod_pkg::SP_BOTH: space_ok = cyc_space == csod_pkg::SP_SUP;
      endcase
    end
    assign hit[g] = bus_cyc.valid && top_ok && is_cs && addr_ok && lane_ok && dir_ok && space_ok;
    assign sync_hit[g] = hit[g] && o.mode;
    assign strobe_ok[g] = o.strobe_timing_select ? data_strobe_line : address_strobe_line;
    assign ack_int[g] = hit[g] && !o.mode && o.size_acknowledge_source != csod_pkg::ACK_EXT;
    assign ack_code[g] = o.size_acknowledge_source;
    assign autovector_enable_hit[g] = hit[g] && bus_cyc.iack && o.space == csod_pkg::SP_CPU
                         && o.autovector_enable;
  end

  // bus-cycle timing: count clocks while cycle valid
  logic [4:0] cyc_cnt_r;
  logic [4:0] ack_target;
  logic any_int;
  always_comb begin
    ack_target = 5'h1f;
    any_int = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (ack_int[i]) begin
        any_int = 1'b1;
        if (ack_code[i] == csod_pkg::ACK_FAST) begin
          ack_target = csod_pkg::FAST_CYCLES;
        end else begin
          ack_target = csod_pkg::BASE_CYCLES + {1'b0, ack_code[i]};
        end
      end
    end
  end

  wire logic ext_done = (|(hit & ~ack_int)) && ext_ack_in && !(|sync_hit);
  wire logic int_done = any_int && (cyc_cnt_r + 5'h1 == ack_target);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt_r <= 5'h00;
    end else if (!bus_cyc.valid || cycle_done) begin
      cyc_cnt_r <= 5'h00;
    end else if (cyc_cnt_r != 5'h1f) begin
      cyc_cnt_r <= cyc_cnt_r + 5'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_n <= {N{1'b1}};
      cycle_done <= 1'b0;
      autovector_out <= 1'b0;
      slow_cycle_pending <= 1'b0;
      match_r <= 16'h0000;
    end else begin
      sel_n <= ~(hit & (strobe_ok | sync_hit)) | {N{cycle_done}};
      cycle_done <= !cycle_done && (int_done || ext_done);
      autovector_out <= !cycle_done && (|autovector_enable_hit);
      slow_cycle_pending <= !cycle_done && (|sync_hit);
      match_r <= 16'(hit);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_top <= 4'h0;
    end else begin
      addr_top <= {4{bus_cyc.addr[19]}};
    end
  end
endmodule // csod_top

// File: tb/csod_properties.sv
// checker: port timing relations of the chip-select decode
`timescale 1ns/100ps
module csod_properties (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire csod_pkg::csod_cyc_t bus_cyc,
  input wire logic [csod_pkg::NUM_SEL-1:0] sel_n,
  input wire logic cycle_done,
  input wire logic slow_cycle_pending,
  input wire logic [3:0] addr_top
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_user;
    bus_cyc.valid && bus_cyc.space == csod_pkg::SP_USER;
  endsequence
  sequence s_top_bad;
    bus_cyc.valid && bus_cyc.addr[23:20] != {4{bus_cyc.addr[19]}};
  endsequence
  a_user_never: assert property (s_user [*2] |=> &sel_n)
    else $error("user space cycle selected");
  a_top_match: assert property (s_top_bad [*2] |=> &sel_n)
    else $error("select with top lines unequal");
  a_top_drive: assert property (bus_cyc.valid |=> addr_top == {4{$past(bus_cyc.addr[19])}})
    else $error("top lines not following line 19");
  a_end_release: assert property (cycle_done |=> &sel_n)
    else $error("select held after termination");
  a_idle_release: assert property (!bus_cyc.valid [*2] |=> &sel_n && !slow_cycle_pending)
    else $error("select active without bus cycle");
  a_done_in_cycle: assert property (cycle_done |-> $past(bus_cyc.valid))
    else $error("termination outside bus cycle");
  a_slow_match: assert property (slow_cycle_pending |-> $past(bus_cyc.valid))
    else $error("slow cycle flagged without bus cycle");
  a_sel_bounded: assert property ($fell(sel_n[1]) |-> ##[1:60] $rose(sel_n[1]))
    else $error("select never released");
endmodule // csod_properties
bind csod_top csod_properties u_props (.sys_clk, .rstn, .bus_cyc, .sel_n, .cycle_done,
  .slow_cycle_pending, .addr_top);

// File: tb/csod_partner.sv
// partner: external peripheral answering with its own acknowledge after a set delay
`timescale 1ns/100ps
module csod_partner (
  input wire logic sys_clk,
  input wire logic sel_n,
  input wire logic [3:0] delay,
  output logic ext_ack_in
);
  logic [3:0] cnt = 4'h0;
  initial ext_ack_in = 1'b0;
  // acknowledge is registered and drops at the first clock edge that samples the select released
  always @(posedge sys_clk) begin
    cnt <= sel_n ? 4'h0 : cnt + 4'h1;
    ext_ack_in <= !sel_n && (cnt + 4'h1 >= delay);
  end
endmodule // csod_partner

// File: tb/tb_chip_select_option_decode.sv
// testbench: register access and bus-cycle qualification of the chip-select decode
`timescale 1ns/100ps
module tb_chip_select_option_decode;
  logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, ds = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata, seed = 32'h166a4;
  logic pready, pslverr, cycle_done, slow_cycle_pending, ext_ack_in, av;
  logic [11:0] sel_n;
  logic [3:0] addr_top, ack_dly = 4'h1;
  csod_pkg::csod_cyc_t cyc = '0;
  int n_mismatch = 0, total_checks = 0, i;
  int regs[int];
  csod_top dut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bus_cyc(cyc), .address_strobe_line(cyc.valid), .data_strobe_line(ds),
    .ext_ack_in, .sel_n, .cycle_done, .autovector_out(av), .slow_cycle_pending, .addr_top);
  csod_partner peer (.sys_clk, .sel_n(sel_n[1]), .delay(ack_dly), .ext_ack_in);
  function automatic logic [31:0] xrand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(logic [39:0] got, logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // pready, read data and error are taken at the edge that samples pready high
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    apb(1, a, d);
    if (regs.exists(a)) regs[a] = d & (a == 8'h80 ? 32'hffffff : 32'hffff);
  endtask
  task automatic rchk(logic [7:0] a);
    apb(0, a, 0);
    chk({err, rd}, {!regs.exists(a), regs.exists(a) ? regs[a] : 0});
  endtask
  task automatic sc(logic [15:0] o, logic [23:0] a, logic [1:0] sp, logic d, int exp,
                    logic [13:0] e, logic ik = 1'b0);
    int n;
    wreg(8'h44, {16'h0, o});
    cyc <= '{1'b1, a, 1'b1, 1'b1, 1'b1, sp, ik};
    ds <= d;
    @(posedge sys_clk);
    #1;
    chk({av, addr_top, slow_cycle_pending, sel_n}, {e[13], {4{a[19]}}, e[12:0]});
    for (n = 1; n < 40 && cycle_done !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (exp > 0) chk(n, exp);
    @(posedge sys_clk);
    cyc.valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  initial forever #20 sys_clk = ~sys_clk;
  initial begin
    regs[8'h80] = 32'hffffff;
    for (i = 0; i < 12; i++) begin
      regs[4*i] = 0;
      regs[8'h40+4*i] = 0;
    end
    regs[0] = 7;
    regs[8'h40] = 32'h7b70;
    repeat (2) @(posedge sys_clk);
    rstn <= 1;
    repeat (3) @(posedge sys_clk);
    foreach (regs[k]) rchk(8'(k));
    wreg(8'h90, 32'h1);
    rchk(8'h90);
    for (i = 2; i < 12; i++) begin
      wreg(8'(8'h40 + 4*i), xrand() & 32'hffff);
      rchk(8'(8'h40 + 4*i));
      wreg(8'(8'h40 + 4*i), 0);
    end
    wreg(8'h40, 0);
    wreg(8'h04, 32'h0100);
    for (i = 0; i < 15; i++) begin
      sc(16'h7820 | 16'(i << 6), 24'h010000 | 24'(xrand() & 32'h7ff), csod_pkg::SP_SUP, 0,
         i == csod_pkg::ACK_FAST ? 2 : 3 + i, 13'h0ffd);
    end
    sc(16'h7820, 24'h010800, csod_pkg::SP_SUP, 0, 40, 13'h0fff);
    sc(16'h7820, 24'h110000, csod_pkg::SP_SUP, 0, 40, 13'h0fff);
    sc(16'h7820, 24'h010000, csod_pkg::SP_USER, 0, 40, 13'h0fff);
    sc(16'h7830, 24'h010000, csod_pkg::SP_SUP, 0, 3, 13'h0ffd);
    sc(16'h7800, 24'h010000, csod_pkg::SP_SUP, 0, 40, 13'h0fff);
    sc(16'h7020, 24'h010000, csod_pkg::SP_SUP, 0, 40, 13'h0fff);
    sc(16'h6820, 24'h010000, csod_pkg::SP_SUP, 0, 3, 13'h0ffd);
    sc(16'h1820, 24'h010000, csod_pkg::SP_SUP, 0, 40, 13'h0fff);
    sc(16'h7c20, 24'h010000, csod_pkg::SP_SUP, 0, 0, 13'h0fff);
    sc(16'h7c20, 24'h010000, csod_pkg::SP_SUP, 1, 3, 13'h0ffd);
    sc(16'hfbe0, 24'h010000, csod_pkg::SP_SUP, 0, 0, 13'h1ffd);
    sc(16'h780b, 24'h01000a, csod_pkg::SP_SUP, 0, 3, 14'h2ffd, 1'b1);
    sc(16'h780b, 24'h010004, csod_pkg::SP_SUP, 0, 40, 14'h0fff, 1'b1);
    sc(16'h7be0, 24'h010000, csod_pkg::SP_SUP, 0, 3, 13'h0ffd);
    ack_dly <= 4'h4;
    sc(16'h7be0, 24'h010000, csod_pkg::SP_SUP, 0, 6, 13'h0ffd);
    wreg(8'h80, 32'hfffffb);
    sc(16'h1820, 24'h010000, csod_pkg::SP_SUP, 0, 3, 13'h0ffd);
    give_verdict();
  end
endmodule // tb_chip_select_option_decode
